/* design/misc_cfg_pkg.sv */
// Package for the local miscellaneous configuration register bank.
// Assumes a byte-addressed access port on the local bus clock.
package misc_cfg_pkg;
    localparam logic [7:0] OFF_PROTECT = 8'h0E;
    localparam logic [7:0] OFF_MISC2 = 8'h0F;
    localparam logic [7:0] OFF_ROM_RANGE = 8'h10;
    localparam logic [6:0] PROTECT_RESET = 7'h30;
    localparam logic [5:0] MISC2_RESET = 6'h00;
    localparam logic [20:0] RANGE_RESET = 21'h000000;
    localparam int RANGE_LSB = 11;
    localparam int MISC2_TMO_EN = 0;
    localparam int MISC2_TMO_SEL = 1;
    localparam int MISC2_DLY_LSB = 2;
    localparam int MISC2_FULL = 5;
    localparam logic [6:0] TIMEOUT_LONG = 7'h40;
    localparam logic [6:0] TIMEOUT_SHORT = 7'h20;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } reg_req_t;

    typedef struct packed {
        logic ready_timeout_en;
        logic ready_timeout_long;
        logic [2:0] write_strobe_delay;
        logic keep_one_free;
    } misc_ctl_t;
endpackage : misc_cfg_pkg

/* design/ready_timeout.sv */
// Local ready timeout counter for a pending local cycle.
// Assumes ready is synchronous to the local bus clock.
`timescale 1ns/10ps
module ready_timeout (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic long_in,
    input wire logic cycle_active_in,
    input wire logic ready_in,
    output logic expire_out
);
    import misc_cfg_pkg::*;
    logic [6:0] count_q;
    logic [6:0] limit;

    assign limit = long_in ? TIMEOUT_LONG : TIMEOUT_SHORT;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= 7'h00;
        end else if (!enable_in || !cycle_active_in || ready_in) begin
            count_q <= 7'h00;
        end else if (count_q != limit) begin
            count_q <= count_q + 7'h01;
        end
    end

    // Pulse once the full count of idle ready clocks elapses
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            expire_out <= 1'b0;
        end else begin
            expire_out <= enable_in && cycle_active_in && !ready_in
                && (count_q == limit - 7'h01);
        end
    end
endmodule : ready_timeout

/* design/local_misc_config_regs.sv */
// Protect boundary, local control two and expansion ROM range registers.
// Assumes both bus sides are arbitrated onto one request port on the
// local bus clock; the EEPROM loader drives its own load strobe.
// Functional notes
// - EEPROM addresses below boundary are read-only
// - Boundary in longwords, resets to 48
// - Enable bit turns ready timeout on
// - Select bit: one 64, zero 32 clocks
// - Three-bit strobe delay for slave writes
// - Full bit keeps one write entry free
// - Otherwise reads retried while write FIFO full
// - Decode enable set only by EEPROM load
// - Range bits map to same address bits
// - Retry PCI until local init done
`timescale 1ns/10ps
module local_misc_config_regs (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input misc_cfg_pkg::reg_req_t req_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out,
    input wire logic eeprom_load_in,
    input wire logic [7:0] eeprom_addr_in,
    input wire logic [31:0] eeprom_data_in,
    input wire logic local_init_done_in,
    input wire logic pci_access_in,
    output logic pci_retry_out,
    input wire logic [7:0] vpd_write_addr_in,
    output logic vpd_write_protected_out,
    input wire logic ds_write_fifo_free_le1_in,
    input wire logic ds_write_fifo_full_in,
    input wire logic ds_read_in,
    output logic ds_write_fifo_stop_out,
    output logic ds_read_retry_out,
    output misc_cfg_pkg::misc_ctl_t misc_ctl_out,
    input wire logic local_cycle_active_in,
    input wire logic local_ready_in,
    output logic local_cycle_abort_out,
    input wire logic [31:0] pci_addr_in,
    input wire logic [31:0] rom_base_in,
    input wire logic rom_base_enable_in,
    output logic rom_hit_out
);
    import misc_cfg_pkg::*;

    logic [6:0] protect_q;
    logic [5:0] misc2_q;
    logic [20:0] range_q;
    logic decode_en_q;
    logic timeout_pulse;
    logic [31:0] rdata_d;

    // Host register writes, byte lane 0 for protect and control two, lanes 1-3 for range
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            protect_q <= PROTECT_RESET;
        end else if (eeprom_load_in && eeprom_addr_in == OFF_PROTECT) begin
            protect_q <= eeprom_data_in[6:0];
        end else if (req_in.wr && req_in.addr == OFF_PROTECT
                && req_in.be[0]) begin
            protect_q <= req_in.wdata[6:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            misc2_q <= MISC2_RESET;
        end else if (eeprom_load_in && eeprom_addr_in == OFF_MISC2) begin
            misc2_q <= eeprom_data_in[5:0];
        end else if (req_in.wr && req_in.addr == OFF_MISC2
                && req_in.be[0]) begin
            misc2_q <= req_in.wdata[5:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            range_q <= RANGE_RESET;
        end else if (eeprom_load_in && eeprom_addr_in == OFF_ROM_RANGE) begin
            range_q <= eeprom_data_in[31:RANGE_LSB];
        end else if (req_in.wr && req_in.addr == OFF_ROM_RANGE) begin
            // Bits 10:1 have no storage at all
            if (req_in.be[1]) begin
                range_q[4:0] <= req_in.wdata[15:11];
            end
            if (req_in.be[2]) begin
                range_q[12:5] <= req_in.wdata[23:16];
            end
            if (req_in.be[3]) begin
                range_q[20:13] <= req_in.wdata[31:24];
            end
        end
    end

    // Bus writes cannot touch the enable; only the loader can
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            decode_en_q <= 1'b0;
        end else if (eeprom_load_in && eeprom_addr_in == OFF_ROM_RANGE) begin
            decode_en_q <= eeprom_data_in[0];
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (req_in.addr)
            OFF_PROTECT: rdata_d = {25'h0000000, protect_q};
            OFF_MISC2: rdata_d = {26'h0000000, misc2_q};
            OFF_ROM_RANGE: rdata_d = {range_q, 10'h000, decode_en_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h0000_0000;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= req_in.rd;
            if (req_in.rd) begin
                rdata_out <= rdata_d;
            end
        end
    end

    assign misc_ctl_out.ready_timeout_en = misc2_q[MISC2_TMO_EN];
    assign misc_ctl_out.ready_timeout_long = misc2_q[MISC2_TMO_SEL];
    assign misc_ctl_out.write_strobe_delay =
        misc2_q[MISC2_DLY_LSB +: 3];
    assign misc_ctl_out.keep_one_free = misc2_q[MISC2_FULL];

    // Longword index compared against boundary; bit 6 covers every address
    always_comb begin
        vpd_write_protected_out = 1'b0;
        if (protect_q[6]) begin
            vpd_write_protected_out = 1'b1;
        end else if (vpd_write_addr_in[7:2] < protect_q[5:0]) begin
            vpd_write_protected_out = 1'b1;
        end
    end

    always_comb begin
        pci_retry_out = 1'b0;
        if (pci_access_in && !local_init_done_in) begin
            pci_retry_out = 1'b1;
        end
    end

    // Reserve one entry so a read address still fits
    always_comb begin
        ds_write_fifo_stop_out = ds_write_fifo_full_in;
        ds_read_retry_out = 1'b0;
        if (misc2_q[MISC2_FULL]) begin
            ds_write_fifo_stop_out = ds_write_fifo_free_le1_in;
        end else if (ds_read_in && ds_write_fifo_full_in) begin
            ds_read_retry_out = 1'b1;
        end
    end

    ready_timeout u_timeout (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .enable_in(misc2_q[MISC2_TMO_EN]),
        .long_in(misc2_q[MISC2_TMO_SEL]),
        .cycle_active_in(local_cycle_active_in),
        .ready_in(local_ready_in),
        .expire_out(timeout_pulse)
    );
    assign local_cycle_abort_out = timeout_pulse;

    // Masked compare; base enable lets software switch decode off
    assign rom_hit_out = decode_en_q && rom_base_enable_in &&
        ((pci_addr_in[31:RANGE_LSB] & range_q) ==
         (rom_base_in[31:RANGE_LSB] & range_q));
endmodule : local_misc_config_regs

/* bench/misc_cfg_asserts.sv */
// Port checker for the misc configuration bank.
// Bound from the bench top; single clock domain.
`timescale 1ns/10ps
module misc_cfg_asserts (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic local_init_done_in,
    input wire logic pci_access_in,
    input wire logic pci_retry_out,
    input wire logic ds_write_fifo_free_le1_in,
    input wire logic ds_write_fifo_full_in,
    input wire logic ds_read_in,
    input wire logic ds_write_fifo_stop_out,
    input wire logic ds_read_retry_out,
    input misc_cfg_pkg::misc_ctl_t misc_ctl_out,
    input wire logic local_cycle_active_in,
    input wire logic local_cycle_abort_out,
    input wire logic rom_base_enable_in,
    input wire logic rom_hit_out
);
    import misc_cfg_pkg::*;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_retry_uninit: assert property (
        pci_access_in && !local_init_done_in |-> pci_retry_out)
        else $error("no retry before init");
    a_keep_free: assert property (misc_ctl_out.keep_one_free
        && ds_write_fifo_free_le1_in |-> ds_write_fifo_stop_out)
        else $error("no stop");
    a_full_retry: assert property (!misc_ctl_out.keep_one_free
        && ds_write_fifo_full_in && ds_read_in |-> ds_read_retry_out)
        else $error("no retry");
    a_rom_gate: assert property (!rom_base_enable_in |-> !rom_hit_out)
        else $error("hit while base disabled");
    a_abort_en: assert property (local_cycle_abort_out
        |-> $past(misc_ctl_out.ready_timeout_en)) else $error("abort while off");
    // Abort before the full wait would cut a slow target short
    a_abort_short: assert property (local_cycle_abort_out
        |-> $past(local_cycle_active_in, 32)) else $error("abort early");
    a_abort_long: assert property (local_cycle_abort_out
        && misc_ctl_out.ready_timeout_long
        |-> $past(local_cycle_active_in, 64)) else $error("long abort early");
    a_abort_pulse: assert property (local_cycle_abort_out |=> !local_cycle_abort_out)
        else $error("abort not a pulse");
    c_abort: cover property (local_cycle_abort_out);
    c_rom_hit: cover property (rom_hit_out);
    c_read_retry: cover property (ds_read_retry_out);
endmodule : misc_cfg_asserts

/* bench/local_target_model.sv */
// Local bus target that answers a pending cycle with ready.
// Assumes the bench drives the cycle-active level on the clock.
`timescale 1ns/10ps
module local_target_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic active_in,
    input wire logic [7:0] lat_in,
    output logic ready_out
);
    logic [7:0] cnt_q;
    // Latency FF outlasts any timeout, so it stands for a dead target
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            cnt_q <= 8'h00;
        else if (!active_in || ready_out)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end
    assign ready_out = active_in && cnt_q == lat_in;
endmodule : local_target_model

/* bench/testbench.sv */
// Self-checking bench for the misc configuration bank.
// Drives the request port and side levels; a target model answers ready.
`timescale 1ns/10ps
module testbench;
    import misc_cfg_pkg::*;
    reg_req_t req_in;
    misc_ctl_t misc_ctl_out;
    logic ref_clk_in, rst_n_in, rvalid_out, eeprom_load_in, pci_retry_out;
    logic local_init_done_in, pci_access_in, vpd_write_protected_out;
    logic ds_write_fifo_free_le1_in, ds_write_fifo_full_in, ds_read_in;
    logic ds_write_fifo_stop_out, ds_read_retry_out, local_cycle_active_in;
    logic local_ready_in, local_cycle_abort_out, rom_base_enable_in;
    logic rom_hit_out;
    logic [7:0] eeprom_addr_in, vpd_write_addr_in, lat;
    logic [31:0] rdata_out, eeprom_data_in, pci_addr_in, rom_base_in;
    int n_errors, cmp_count, cyc, k, g;
    local_misc_config_regs u_local_misc_config_regs (.*);
    local_target_model u_local_target_model (.ref_clk_in, .rst_n_in,
        .active_in(local_cycle_active_in), .lat_in(lat),
        .ready_out(local_ready_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    task chk(input string n, input logic [32:0] e, input logic [32:0] v);
        cmp_count++;
        if (v !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, v);
            n_errors++;
        end
    endtask : chk
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in) req_in <= {w, !w, a, d, 4'hF};
        @(posedge ref_clk_in) req_in <= '0;
        #1;
    endtask : acc
    task rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, e);
        chk("rdata", {1'b1, e}, {rvalid_out, rdata_out});
    endtask : rd
    task t_regs;
        rd(8'h0E, 32'h30);
        rd(8'h0F, 32'h0);
        rd(8'h10, 32'h0);
        acc(1'b1, 8'h0E, 32'hFF);
        rd(8'h0E, 32'h7F);
        acc(1'b1, 8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'hFFFFF800);
        rd(8'h20, 32'h0);
    endtask : t_regs
    task t_protect;
        logic [7:0] b;
        for (int i = 0; i < 2; i++) begin
            b = i ? 8'h01 : 8'h30;
            acc(1'b1, 8'h0E, {24'h0, b});
            @(posedge ref_clk_in) vpd_write_addr_in <= {b[5:0], 2'h0} - 8'h01;
            #1 chk("prot", 1, vpd_write_protected_out);
            @(posedge ref_clk_in) vpd_write_addr_in <= {b[5:0], 2'h0};
            #1 chk("prot", 0, vpd_write_protected_out);
        end
    endtask : t_protect
    task t_fifo;
        acc(1'b1, 8'h0F, 32'h3C);
        @(posedge ref_clk_in) ds_write_fifo_free_le1_in <= 1'b1;
        #1 chk("ctl", 6'h0F, misc_ctl_out);
        chk("stop", 1, ds_write_fifo_stop_out);
        acc(1'b1, 8'h0F, 32'h08);
        @(posedge ref_clk_in) {ds_write_fifo_full_in, ds_read_in} <= 2'h3;
        #1 chk("ctl", 6'h04, misc_ctl_out);
        chk("retry", 1, ds_read_retry_out);
    endtask : t_fifo
    task t_rom;
        @(posedge ref_clk_in) begin
            {eeprom_load_in, eeprom_data_in} <= {1'b1, 32'hFFFFF001};
        end
        @(posedge ref_clk_in) eeprom_load_in <= 1'b0;
        rd(8'h10, 32'hFFFFF001);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_in) begin
                rom_base_enable_in <= i != 2;
                pci_addr_in <= i == 1 ? 32'h000C1000 : 32'h000C0400;
            end
            #1 chk("hit", i == 0, rom_hit_out);
        end
    endtask : t_rom
    task t_tmo;
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, 8'h0F, m == 2 ? 32'h3 : {31'h0, m != 0});
            @(posedge ref_clk_in) begin
                local_cycle_active_in <= 1'b1;
                lat <= m == 3 ? 8'h02 : 8'hFF;
            end
            k = 0;
            do begin
                @(posedge ref_clk_in);
                #1 k++;
            end while (local_cycle_abort_out !== 1'b1 && k < 80);
            g = m % 3 == 0 ? k : k >= 32 * m && k <= 32 * m + 2;
            chk("tmo", m % 3 == 0 ? 80 : 1, g);
            @(posedge ref_clk_in) local_cycle_active_in <= 1'b0;
        end
    endtask : t_tmo
    task t_init;
        @(posedge ref_clk_in) pci_access_in <= 1'b1;
        #1 chk("retry", 1, pci_retry_out);
        @(posedge ref_clk_in) local_init_done_in <= 1'b1;
        #1 chk("retry", 0, pci_retry_out);
    endtask : t_init
    task complete_run;
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // Generous ceiling: the whole run needs about 330 cycles
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            complete_run;
        end
    end
    initial begin
        {req_in, rst_n_in, eeprom_load_in, local_init_done_in, pci_access_in,
            vpd_write_addr_in, ds_write_fifo_free_le1_in, ds_write_fifo_full_in,
            ds_read_in, local_cycle_active_in, pci_addr_in, rom_base_enable_in} = '0;
        {eeprom_addr_in, eeprom_data_in} = {8'h10, 32'h0};
        {rom_base_in, lat} = {32'h000C0000, 8'hFF};
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        t_regs;
        t_protect;
        t_fifo;
        t_rom;
        t_tmo;
        t_init;
        complete_run;
    end
endmodule : testbench
bind local_misc_config_regs misc_cfg_asserts u_misc_cfg_asserts (.*);
